// *** src/dsd_pkg.sv ***
// Constants and types for the data-space decoder with program-memory window
// ==========================================
package dsd_pkg;
	// ==========================================
	// Widths
	localparam int DATA_W     = 8;
	localparam int WIN_OFS_W  = 6;
	localparam int WIN_BASE_W = 6;
	localparam int PRG_ADDR_W = 12;
	localparam int STACK_DEPTH = 6;

	// ==========================================
	// Data-space offsets
	localparam logic [7:0] ADDR_BANK_HI   = 8'h3F;
	localparam logic [7:0] ADDR_WIN_LO    = 8'h40;
	localparam logic [7:0] ADDR_WIN_HI    = 8'h7F;
	localparam logic [7:0] ADDR_CORE_LO   = 8'h80;
	localparam logic [7:0] ADDR_CORE_HI   = 8'h83;
	localparam logic [7:0] ADDR_RAM_LO    = 8'h84;
	localparam logic [7:0] ADDR_RAM_HI    = 8'hBF;
	localparam logic [7:0] ADDR_PDAT_LO   = 8'hC0;
	localparam logic [7:0] ADDR_PDAT_HI   = 8'hC2;
	localparam logic [7:0] ADDR_PDIR_LO   = 8'hC4;
	localparam logic [7:0] ADDR_PDIR_HI   = 8'hC6;
	localparam logic [7:0] ADDR_INT_OPT   = 8'hC8;
	localparam logic [7:0] ADDR_WIN_BASE  = 8'hC9;
	localparam logic [7:0] ADDR_POPT_LO   = 8'hCC;
	localparam logic [7:0] ADDR_POPT_HI   = 8'hCE;
	localparam logic [7:0] ADDR_PERIPH_LO = 8'hD0;
	localparam logic [7:0] ADDR_PERIPH_HI = 8'hDC;
	localparam logic [7:0] ADDR_BANK_REG  = 8'hE8;
	localparam logic [7:0] ADDR_EE_CTL    = 8'hEA;
	localparam logic [7:0] ADDR_ACC       = 8'hFF;

	// ==========================================
	// Field positions and fixed values
	localparam int          BANK_RAM2_BIT = 4;
	localparam int          BANK_EE0_BIT  = 0;
	localparam logic [7:0]  UNDEF_RD_VAL  = 8'h00;
	localparam logic [11:0] STACK_RST_VAL = 12'h000;

	// ==========================================
	// Decoded target region, one-hot
	typedef enum logic [5:0] {
		RG_NONE   = 6'h01,
		RG_BANK   = 6'h02,
		RG_WIN    = 6'h04,
		RG_CORE   = 6'h08,
		RG_RAM    = 6'h10,
		RG_PERIPH = 6'h20
	} dsd_region_t;
endpackage

// *** src/dsd_ret_stack.sv ***
// Six-level return address stack kept apart from data space
`timescale 1ns/100ps
module dsd_ret_stack (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// Push and pop from the core
	input  wire logic        push,
	input  wire logic        pop,
	input  wire logic [11:0] pushAddr,
	// Top of stack
	output logic      [11:0] stackTop
);
	// ==========================================
	// Storage: entry 0 is the top
	logic [11:0] ent_q [dsd_pkg::STACK_DEPTH];  // Entries
	logic [11:0] ent_d [dsd_pkg::STACK_DEPTH];  // Next entries

	// Shift down on push, up on pop; overflow drops the oldest
	always_comb begin
		for (int i = 0; i < dsd_pkg::STACK_DEPTH; i++) begin
			ent_d[i] = ent_q[i];
		end
		if (push && pop) begin  // Replace top
			ent_d[0] = pushAddr;
		end else if (push) begin
			ent_d[0] = pushAddr;
			for (int i = 1; i < dsd_pkg::STACK_DEPTH; i++) begin
				ent_d[i] = ent_q[i-1];
			end
		end else if (pop) begin
			for (int i = 0; i < dsd_pkg::STACK_DEPTH - 1; i++) begin
				ent_d[i] = ent_q[i+1];
			end
			ent_d[dsd_pkg::STACK_DEPTH-1] = dsd_pkg::STACK_RST_VAL;
		end
	end

	// One flop per entry
	genvar g;
	generate
		for (g = 0; g < dsd_pkg::STACK_DEPTH; g++) begin : gEnt
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					ent_q[g] <= dsd_pkg::STACK_RST_VAL;
				end else begin
					ent_q[g] <= ent_d[g];
				end
			end
		end
	endgenerate

	assign stackTop = ent_q[0];

	// Pushed address shows on top next cycle
	property p_stack_push;
		@(posedge clk_sys) disable iff (!arst_n)
		push |=> stackTop == $past(pushAddr);
	endproperty
	a_stack_push: assert property (p_stack_push) else $error("push lost");

	// Pop then shows what was second
	property p_stack_pop;
		@(posedge clk_sys) disable iff (!arst_n)
		(pop && !push) |=> stackTop == $past(ent_q[1]);
	endproperty
	a_stack_pop: assert property (p_stack_pop) else $error("pop wrong");
endmodule

// *** src/dsd_data_decoder.sv ***
// Data-space decoder with read-only program-memory window and bank register
`timescale 1ns/100ps
module dsd_data_decoder (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// Core data-space access
	input  wire logic [7:0]  coreAddr,
	input  wire logic        coreRd,
	input  wire logic        coreWr,
	input  wire logic [7:0]  coreWrData,
	// Core stack port
	input  wire logic        stackPush,
	input  wire logic        stackPop,
	input  wire logic [11:0] stackPushAddr,
	// Read data returned by targets
	input  wire logic [7:0]  bankRdData,
	input  wire logic [7:0]  coreRegRdData,
	input  wire logic [7:0]  ramRdData,
	input  wire logic [7:0]  periphRdData,
	input  wire logic [7:0]  prgRdData,
	// Access to targets
	output logic      [7:0]  accAddr_q,
	output logic      [7:0]  accWrData_q,
	output logic             accWr_q,
	output logic             accRd_q,
	output logic             bankSel_q,
	output logic             coreSel_q,
	output logic             ramSel_q,
	output logic             periphSel_q,
	// Program memory window
	output logic      [11:0] prgAddr_q,
	output logic             prgRd_q,
	// Bank selection
	output logic             bankRamPage2_q,
	output logic             bankEepPage0_q,
	// Read answer
	output logic      [7:0]  rdData_q,
	output logic             rdValid_q,
	// Return stack top
	output logic      [11:0] stackTop
);
	// ==========================================
	// Address decode
	function automatic dsd_pkg::dsd_region_t decodeAddr(input logic [7:0] a);
		if (a <= dsd_pkg::ADDR_BANK_HI) begin
			decodeAddr = dsd_pkg::RG_BANK;
		end else if (a <= dsd_pkg::ADDR_WIN_HI) begin
			decodeAddr = dsd_pkg::RG_WIN;
		end else if (a <= dsd_pkg::ADDR_CORE_HI || a == dsd_pkg::ADDR_ACC) begin
			decodeAddr = dsd_pkg::RG_CORE;
		end else if (a <= dsd_pkg::ADDR_RAM_HI) begin
			decodeAddr = dsd_pkg::RG_RAM;
		end else if ((a >= dsd_pkg::ADDR_PDAT_LO && a <= dsd_pkg::ADDR_PDAT_HI)
			|| (a >= dsd_pkg::ADDR_PDIR_LO && a <= dsd_pkg::ADDR_PDIR_HI)
			|| (a >= dsd_pkg::ADDR_POPT_LO && a <= dsd_pkg::ADDR_POPT_HI)) begin
			decodeAddr = dsd_pkg::RG_PERIPH;
		end else if (a == dsd_pkg::ADDR_INT_OPT || a == dsd_pkg::ADDR_EE_CTL
			|| (a >= dsd_pkg::ADDR_PERIPH_LO && a <= dsd_pkg::ADDR_PERIPH_HI)) begin
			decodeAddr = dsd_pkg::RG_PERIPH;
		end else begin
			// Reserved holes, window base and bank register
			decodeAddr = dsd_pkg::RG_NONE;
		end
	endfunction

	dsd_pkg::dsd_region_t curRegion;  // Region of the present access
	logic winBaseWr;                  // Write hits window base
	logic bankRegWr;                  // Write hits bank register

	always_comb begin
		curRegion = decodeAddr(coreAddr);
		winBaseWr = coreWr && coreAddr == dsd_pkg::ADDR_WIN_BASE;
		bankRegWr = coreWr && coreAddr == dsd_pkg::ADDR_BANK_REG;
	end

	// ==========================================
	// Window base register: no reset, holds through any reset
	logic [5:0] winBase_q;  // Upper program-memory address bits
	logic [5:0] winBase_d;
	logic       winSeen_q;  // Base written once; unknown before, so hold check waits
	logic       winSeen_d;

	// Only a write at C9h loads it; reads leave it alone
	always_comb begin
		winBase_d = winBase_q;
		winSeen_d = winSeen_q || winBaseWr;
		if (winBaseWr) begin
			winBase_d = coreWrData[dsd_pkg::WIN_BASE_W-1:0];
		end
	end

	// Deliberately no reset branch: contents undefined until first write
	always_ff @(posedge clk_sys) begin
		winBase_q <= winBase_d;
		winSeen_q <= winSeen_d;
	end

	// ==========================================
	// Bank register: write-only, also not cleared by reset
	logic bankRam2_d;
	logic bankEe0_d;

	always_comb begin
		bankRam2_d = bankRamPage2_q;
		bankEe0_d  = bankEepPage0_q;
		if (bankRegWr) begin
			bankRam2_d = coreWrData[dsd_pkg::BANK_RAM2_BIT];
			bankEe0_d  = coreWrData[dsd_pkg::BANK_EE0_BIT];
		end
	end

	// Both bits may be set together; that conflict is left to software
	always_ff @(posedge clk_sys) begin
		bankRamPage2_q <= bankRam2_d;
		bankEepPage0_q <= bankEe0_d;
	end

	// ==========================================
	// Access stage: registered selects to the targets
	logic [7:0]  accAddr_d;
	logic [7:0]  accWrData_d;
	logic        accWr_d;
	logic        accRd_d;
	logic        bankSel_d;
	logic        coreSel_d;
	logic        ramSel_d;
	logic        periphSel_d;
	logic [11:0] prgAddr_d;
	logic        prgRd_d;
	logic        rdPend_d;
	logic        rdPend_q;  // Any read in flight, mapped or not
	dsd_pkg::dsd_region_t rdRegion_d;
	dsd_pkg::dsd_region_t rdRegion_q;  // Region for the answer mux

	always_comb begin
		accAddr_d   = coreAddr;
		accWrData_d = coreWrData;
		accWr_d     = 1'b0;
		accRd_d     = 1'b0;
		bankSel_d   = 1'b0;
		coreSel_d   = 1'b0;
		ramSel_d    = 1'b0;
		periphSel_d = 1'b0;
		prgAddr_d   = prgAddr_q;
		prgRd_d     = 1'b0;
		rdPend_d    = coreRd;
		rdRegion_d  = coreRd ? curRegion : dsd_pkg::RG_NONE;
		case (curRegion)
			dsd_pkg::RG_BANK: begin
				bankSel_d = coreRd || coreWr;
				accRd_d   = coreRd;
				accWr_d   = coreWr;
			end
			dsd_pkg::RG_WIN: begin
				// Reads only; writes fall on nothing
				prgRd_d = coreRd;
				if (coreRd) begin
					prgAddr_d = {winBase_q, coreAddr[dsd_pkg::WIN_OFS_W-1:0]};
				end
			end
			dsd_pkg::RG_CORE: begin
				coreSel_d = coreRd || coreWr;
				accRd_d   = coreRd;
				accWr_d   = coreWr;
			end
			dsd_pkg::RG_RAM: begin
				ramSel_d = coreRd || coreWr;
				accRd_d  = coreRd;
				accWr_d  = coreWr;
			end
			dsd_pkg::RG_PERIPH: begin
				periphSel_d = coreRd || coreWr;
				accRd_d     = coreRd;
				accWr_d     = coreWr;
			end
			default: begin
				// Holes and write-only registers: no target strobed
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			accAddr_q   <= 8'h00;
			accWrData_q <= 8'h00;
			accWr_q     <= 1'b0;
			accRd_q     <= 1'b0;
			bankSel_q   <= 1'b0;
			coreSel_q   <= 1'b0;
			ramSel_q    <= 1'b0;
			periphSel_q <= 1'b0;
			prgAddr_q   <= 12'h000;
			prgRd_q     <= 1'b0;
			rdPend_q    <= 1'b0;
			rdRegion_q  <= dsd_pkg::RG_NONE;
		end else begin
			accAddr_q   <= accAddr_d;
			accWrData_q <= accWrData_d;
			accWr_q     <= accWr_d;
			accRd_q     <= accRd_d;
			bankSel_q   <= bankSel_d;
			coreSel_q   <= coreSel_d;
			ramSel_q    <= ramSel_d;
			periphSel_q <= periphSel_d;
			prgAddr_q   <= prgAddr_d;
			prgRd_q     <= prgRd_d;
			rdPend_q    <= rdPend_d;
			rdRegion_q  <= rdRegion_d;
		end
	end

	// ==========================================
	// Answer stage: targets answer during the access cycle
	logic [7:0] rdData_d;

	always_comb begin
		case (rdRegion_q)
			dsd_pkg::RG_BANK:   rdData_d = bankRdData;
			dsd_pkg::RG_WIN:    rdData_d = prgRdData;
			dsd_pkg::RG_CORE:   rdData_d = coreRegRdData;
			dsd_pkg::RG_RAM:    rdData_d = ramRdData;
			dsd_pkg::RG_PERIPH: rdData_d = periphRdData;
			default:            rdData_d = dsd_pkg::UNDEF_RD_VAL;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdData_q  <= 8'h00;
			rdValid_q <= 1'b0;
		end else begin
			rdData_q  <= rdData_d;
			rdValid_q <= rdPend_q;
		end
	end

	// ==========================================
	// Return stack
	dsd_ret_stack uStack (
		.clk_sys  (clk_sys),
		.arst_n   (arst_n),
		.push     (stackPush),
		.pop      (stackPop),
		.pushAddr (stackPushAddr),
		.stackTop (stackTop)
	);

	// ==========================================
	// Checks
	property p_win_read;
		@(posedge clk_sys) disable iff (!arst_n)
		(coreRd && coreAddr >= 8'h40 && coreAddr <= 8'h7F) |=> prgRd_q && !accRd_q;
	endproperty
	a_win_read: assert property (p_win_read) else $error("window read missed");

	property p_win_addr;
		@(posedge clk_sys) disable iff (!arst_n)
		(coreRd && coreAddr[7:6] == 2'b01)
			|=> prgAddr_q == {$past(winBase_q), $past(coreAddr[5:0])};
	endproperty
	a_win_addr: assert property (p_win_addr) else $error("window address wrong");

	property p_win_base_hold;
		@(posedge clk_sys) disable iff (!arst_n)
		winSeen_q && !(coreWr && coreAddr == 8'hC9) |=> winBase_q == $past(winBase_q);
	endproperty
	a_win_base_hold: assert property (p_win_base_hold) else $error("base moved");

	property p_win_base_load;
		@(posedge clk_sys) disable iff (!arst_n)
		(coreWr && coreAddr == 8'hC9) |=> winBase_q == $past(coreWrData[5:0]);
	endproperty
	a_win_base_load: assert property (p_win_base_load) else $error("base not loaded");

	property p_win_write;
		@(posedge clk_sys) disable iff (!arst_n)
		(coreWr && coreAddr[7:6] == 2'b01) |=> !prgRd_q && !accWr_q;
	endproperty
	a_win_write: assert property (p_win_write) else $error("window write leaked");

	property p_bank_sel;
		@(posedge clk_sys) disable iff (!arst_n)
		((coreRd || coreWr) && coreAddr <= 8'h3F) |=> bankSel_q && !ramSel_q;
	endproperty
	a_bank_sel: assert property (p_bank_sel) else $error("bank not selected");

	property p_ram_sel;
		@(posedge clk_sys) disable iff (!arst_n)
		(coreRd || coreWr) |=> ramSel_q == ($past(coreAddr) >= 8'h84 && $past(coreAddr) <= 8'hBF);
	endproperty
	a_ram_sel: assert property (p_ram_sel) else $error("RAM decode wrong");

	property p_core_sel;
		@(posedge clk_sys) disable iff (!arst_n)
		(coreRd || coreWr) |=> coreSel_q == ($past(coreAddr) inside {[8'h80:8'h83], 8'hFF});
	endproperty
	a_core_sel: assert property (p_core_sel) else $error("core decode wrong");

	property p_port_sel;
		@(posedge clk_sys) disable iff (!arst_n)
		(coreRd || coreWr) && coreAddr inside {8'hC3, 8'hC7, 8'hC9, 8'hCF}
			|=> !periphSel_q && !accRd_q && !accWr_q;
	endproperty
	a_port_sel: assert property (p_port_sel) else $error("hole decoded");

	property p_periph_sel;
		@(posedge clk_sys) disable iff (!arst_n)
		(coreRd && coreAddr inside {8'hC8, 8'hEA, [8'hD0:8'hDC]}) |=> periphSel_q;
	endproperty
	a_periph_sel: assert property (p_periph_sel) else $error("peripheral missed");

	property p_bank_reg;
		@(posedge clk_sys) disable iff (!arst_n)
		(coreWr && coreAddr == 8'hE8)
			|=> bankRamPage2_q == $past(coreWrData[4]) && bankEepPage0_q == $past(coreWrData[0]);
	endproperty
	a_bank_reg: assert property (p_bank_reg) else $error("bank register wrong");

	property p_base_read;
		@(posedge clk_sys) disable iff (!arst_n)
		(coreRd && !coreWr && coreAddr == 8'hC9)
			|=> ##1 rdValid_q && rdData_q == 8'h00;
	endproperty
	a_base_read: assert property (p_base_read) else $error("base read answered");
endmodule

// *** tb/dsd_target_model.sv ***
// Read targets that answer the decoder's select pulses
`timescale 1ns/100ps
module dsd_target_model (
	// Selects and address from the decoder
	input  wire logic [7:0]  accAddr_q,
	input  wire logic        bankSel_q,
	input  wire logic        coreSel_q,
	input  wire logic        ramSel_q,
	input  wire logic        periphSel_q,
	input  wire logic [11:0] prgAddr_q,
	input  wire logic        prgRd_q,
	// Read data back to the decoder
	output logic      [7:0]  bankRdData,
	output logic      [7:0]  coreRegRdData,
	output logic      [7:0]  ramRdData,
	output logic      [7:0]  periphRdData,
	output logic      [7:0]  prgRdData
);
	// ==========================================
	// Program memory content
	logic [7:0] prgByte; // Fixed pattern of the address
	logic [7:0] ramByte; // RAM byte pattern
	assign prgByte = prgAddr_q[7:0] ^ {prgAddr_q[11:8], prgAddr_q[11:8]};
	assign ramByte = accAddr_q ^ 8'h5A;
	// Unselected targets show the inverse, so stale data never matches
	assign prgRdData     = prgRd_q ? prgByte : ~prgByte;
	assign ramRdData     = ramSel_q ? ramByte : ~ramByte;
	assign bankRdData    = bankSel_q ? 8'hB1 : 8'h4E;
	assign coreRegRdData = coreSel_q ? 8'hC2 : 8'h3D;
	assign periphRdData  = periphSel_q ? 8'hD3 : 8'h2C;
endmodule

// *** tb/test_data_space_decoder_rom_window.sv ***
// Self-checking bench for the data-space decoder
`timescale 1ns/100ps
module test_data_space_decoder_rom_window;
	// ==========================================
	// Core-side drive
	logic        clk_sys       = 1'b0;
	logic        arst_n        = 1'b0;
	logic [7:0]  coreAddr      = 8'h00;
	logic        coreRd        = 1'b0;
	logic        coreWr        = 1'b0;
	logic [7:0]  coreWrData    = 8'h00;
	logic        stackPush     = 1'b0;
	logic        stackPop      = 1'b0;
	logic [11:0] stackPushAddr = 12'h000;
	// Target data and decoder outputs
	logic [7:0]  bankRdData, coreRegRdData, ramRdData, periphRdData, prgRdData;
	logic [7:0]  accAddr_q, accWrData_q, rdData_q;
	logic        accWr_q, accRd_q, bankSel_q, coreSel_q, ramSel_q, periphSel_q;
	logic        prgRd_q, bankRamPage2_q, bankEepPage0_q, rdValid_q;
	logic [11:0] prgAddr_q, stackTop;
	int          miscompares = 0;
	int          tests_run   = 0;

	// 25 MHz clock
	always #20 clk_sys = ~clk_sys;

	dsd_data_decoder dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .coreAddr(coreAddr),
		.coreRd(coreRd), .coreWr(coreWr), .coreWrData(coreWrData), .stackPush(stackPush),
		.stackPop(stackPop), .stackPushAddr(stackPushAddr), .bankRdData(bankRdData),
		.coreRegRdData(coreRegRdData), .ramRdData(ramRdData), .periphRdData(periphRdData),
		.prgRdData(prgRdData), .accAddr_q(accAddr_q), .accWrData_q(accWrData_q),
		.accWr_q(accWr_q), .accRd_q(accRd_q), .bankSel_q(bankSel_q), .coreSel_q(coreSel_q),
		.ramSel_q(ramSel_q), .periphSel_q(periphSel_q), .prgAddr_q(prgAddr_q),
		.prgRd_q(prgRd_q), .bankRamPage2_q(bankRamPage2_q), .bankEepPage0_q(bankEepPage0_q),
		.rdData_q(rdData_q), .rdValid_q(rdValid_q), .stackTop(stackTop));

	dsd_target_model tgt_u (.accAddr_q(accAddr_q), .bankSel_q(bankSel_q),
		.coreSel_q(coreSel_q), .ramSel_q(ramSel_q), .periphSel_q(periphSel_q),
		.prgAddr_q(prgAddr_q), .prgRd_q(prgRd_q), .bankRdData(bankRdData),
		.coreRegRdData(coreRegRdData), .ramRdData(ramRdData), .periphRdData(periphRdData),
		.prgRdData(prgRdData));

	// ==========================================
	// Shared tasks
	// Inputs move 1 ns after the edge, away from sampling
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Expected program byte, same pattern the model holds
	function automatic logic [7:0] prgB(input logic [11:0] a);
		return a[7:0] ^ {a[11:8], a[11:8]};
	endfunction

	// One read or write; sel is {bank, core, ram, periph, window}
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
			input logic [4:0] sel, input logic [7:0] expRd);
		coreWr     = wr;
		coreRd     = !wr;
		coreAddr   = a;
		coreWrData = d;
		step();
		coreWr = 1'b0;
		coreRd = 1'b0;
		chk({5'h00, accWr_q, accRd_q, bankSel_q, coreSel_q, ramSel_q, periphSel_q, prgRd_q},
			{5'h00, wr & |sel[4:1], !wr & |sel[4:1], sel});
		if (wr && |sel[4:1])
			chk({4'h0, accWrData_q}, {4'h0, d});
		step();
		// Every read is answered, unmapped ones too
		if (!wr)
			chk({3'h0, rdValid_q, rdData_q}, {4'h1, expRd});
		else
			chk({11'h000, rdValid_q}, 12'h000);
	endtask

	// Stack request held across calls, released by the caller
	task automatic stk(input logic pu, input logic po, input logic [11:0] a,
			input logic [11:0] exp);
		stackPush     = pu;
		stackPop      = po;
		stackPushAddr = a;
		step();
		chk(stackTop, exp);
	endtask

	// ==========================================
	// Scenarios
	// Window placed at several bases, both ends of the range
	task automatic t_window();
		logic [5:0] bases [4] = '{6'h03, 6'h00, 6'h3F, 6'h15};
		logic [7:0] adrs  [4] = '{8'h45, 8'h40, 8'h7F, 8'h6A};
		for (int i = 0; i < 4; i++) begin
			// Unused top bits set to show they are dropped; base written first
			acc(1'b1, 8'hC9, {2'b11, bases[i]}, 5'h00, 8'h00);
			acc(1'b0, adrs[i], 8'h00, 5'h01, prgB({bases[i], adrs[i][5:0]}));
			chk(prgAddr_q, {bases[i], adrs[i][5:0]});
		end
	endtask

	// Window writes and base reads leave everything alone
	task automatic t_protect();
		acc(1'b1, 8'h50, 8'h55, 5'h00, 8'h00);
		acc(1'b0, 8'hC9, 8'h00, 5'h00, 8'h00);
		acc(1'b0, 8'h45, 8'h00, 5'h01, prgB(12'h545));
		chk(prgAddr_q, 12'h545);
	endtask

	// Every mapped region except the window, and the reserved holes
	task automatic t_decode();
		logic [12:0] tbl [24] = '{13'h1000, 13'h103F, 13'h0880, 13'h0883, 13'h08FF,
			13'h0484, 13'h04BF, 13'h02C0, 13'h02C2, 13'h02C4, 13'h02C6, 13'h02C8, 13'h02CC,
			13'h02CE, 13'h02D0, 13'h02DC, 13'h02EA, 13'h00C3, 13'h00C7, 13'h00CA, 13'h00CF,
			13'h00DD, 13'h00E9, 13'h00FE};
		logic [7:0] ex;
		for (int i = 0; i < 24; i++) begin
			ex = tbl[i][12] ? 8'hB1 : tbl[i][11] ? 8'hC2 : tbl[i][10] ? tbl[i][7:0] ^ 8'h5A :
				tbl[i][9] ? 8'hD3 : 8'h00;
			acc(1'b0, tbl[i][7:0], 8'h00, tbl[i][12:8], ex);
		end
		acc(1'b1, 8'h90, 8'hA5, 5'h04, 8'h00);
		acc(1'b1, 8'hD4, 8'h3C, 5'h02, 8'h00);
	endtask

	// Bank register bits, write-only
	task automatic t_bank();
		acc(1'b1, 8'hE8, 8'h10, 5'h00, 8'h00);
		chk({10'h000, bankRamPage2_q, bankEepPage0_q}, 12'h002);
		acc(1'b1, 8'hE8, 8'h01, 5'h00, 8'h00);
		chk({10'h000, bankRamPage2_q, bankEepPage0_q}, 12'h001);
		acc(1'b0, 8'hE8, 8'h00, 5'h00, 8'h00);
	endtask

	// Reset in mid-run keeps window base and bank bits
	task automatic t_reset();
		acc(1'b1, 8'hC9, 8'h2A, 5'h00, 8'h00);
		acc(1'b1, 8'hE8, 8'h10, 5'h00, 8'h00);
		arst_n = 1'b0;
		step();
		chk({rdValid_q, prgRd_q, accRd_q, prgAddr_q[8:0]}, 12'h000);
		step();
		arst_n = 1'b1;
		step();
		chk({10'h000, bankRamPage2_q, bankEepPage0_q}, 12'h002);
		acc(1'b0, 8'h41, 8'h00, 5'h01, prgB(12'hA81));
		chk(prgAddr_q, 12'hA81);
	endtask

	// Overflow drops the oldest, underflow gives zero
	task automatic t_stack();
		for (int i = 1; i <= 7; i++)
			stk(1'b1, 1'b0, 12'(i * 12'h111), 12'(i * 12'h111));
		for (int i = 6; i >= 1; i--)
			stk(1'b0, 1'b1, 12'h000, (i >= 2) ? 12'(i * 12'h111) : 12'h000);
		stk(1'b1, 1'b0, 12'hABC, 12'hABC);
		stk(1'b1, 1'b1, 12'hDEF, 12'hDEF);
		stk(1'b0, 1'b1, 12'h000, 12'h000);
		stackPush = 1'b0;
		stackPop  = 1'b0;
	endtask

	// ==========================================
	// Verdict, one place for normal end and timeout
	task automatic close_out();
		$display("Comparisons %0d, miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence, reset held 10 cycles
	initial begin
		repeat (10) step();
		arst_n = 1'b1;
		step();
		t_window();
		t_protect();
		t_decode();
		t_bank();
		t_reset();
		t_stack();
		close_out();
	end

	// Watchdog, well past the 116 cycles needed
	initial begin
		#(40 * 5000);
		miscompares++;
		close_out();
	end
endmodule
